//--- hdl/uab_pkg.sv
/*
  Constants, register map and types of the buffered 8N1 serial port.
  Assumes a 10 MHz reference clock and an Avalon-MM slave with byte addresses.
*/
// Function
// - Eight data bits, no parity, one stop
// - Non-inverted logic levels on both lines
// - Newer revision: lines follow enabled timers
// - Older revision: transmit on SDA, receive SCL
// - Buffer receive data only after enable
// - Read reports occupancy before read, max 32
// - Up to 64 queued bytes, occupancy returned
// - Flush discards received bytes only, value ignored
// - Newer revision: 16-bit factor, 48 MHz base
// - Older revision: 8-bit factor, timer base
package uab_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NEW_BASE_HZ   = 48_000_000;
  localparam int unsigned ACC_UNIT_HZ   = 100_000;
  localparam logic [23:0] ACC_PER_CLK   = 24'(CLK_HZ / ACC_UNIT_HZ);
  localparam logic [23:0] NEW_STEP      = 24'(NEW_BASE_HZ / ACC_UNIT_HZ);
  localparam logic [16:0] NEW_SPAN      = 17'h10000;
  localparam logic [8:0]  OLD_SPAN      = 9'h100;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned RX_DEPTH     = 32;
  localparam int unsigned TX_DEPTH     = 64;
  localparam int unsigned TX_MAX_BYTES = 56;
  localparam int unsigned FLEX_LINES   = 16;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BAUD   = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_FLUSH  = 8'h14;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_RXEN_BIT = 0;
  localparam int unsigned CTRL_REV_BIT  = 1;
  localparam int unsigned CTRL_OFS_LSB  = 4;
  localparam int unsigned CTRL_TMR_LSB  = 8;
  localparam logic        CTRL_RXEN_RST = 1'b0;
  localparam logic        CTRL_REV_RST  = 1'b1;
  localparam logic [3:0]  CTRL_OFS_RST  = 4'h4;
  localparam logic [1:0]  CTRL_TMR_RST  = 2'h0;
  localparam logic [15:0] BAUD_RST      = 16'hF63C;
  localparam int unsigned STAT_RXCNT_LSB = 0;
  localparam int unsigned STAT_BUSY_BIT  = 8;
  localparam int unsigned STAT_OVF_BIT   = 9;
  localparam int unsigned STAT_FERR_BIT  = 10;
  localparam int unsigned STAT_TXCNT_LSB = 16;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_START = 2'b01,
    S_DATA  = 2'b10,
    S_STOP  = 2'b11
  } uab_ser_t;

endpackage : uab_pkg

//--- hdl/uab_top.sv
/*
  Buffered 8N1 serial port: Avalon-MM register slave, receive FIFO, transmit
  FIFO, baud generators and pin mapping for both hardware revisions.
  Assumes one 10 MHz clock, an asynchronous active-low reset and pins that
  are asynchronous to the clock.
*/
`timescale 1ns/1ps

module uab_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    flush_i,
  input  wire logic                    in_valid_i,
  output logic                         in_ready_o,
  input  wire logic [WIDTH-1:0]        in_data_i,
  output logic                         out_valid_o,
  input  wire logic                    out_ready_i,
  output logic [WIDTH-1:0]             out_data_o,
  output logic [$clog2(DEPTH):0]       count_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign count_o     = count_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : uab_fifo

module uab_top #(
  parameter int unsigned TIMER_BASE_HZ = 4_000_000
) (
  input  wire logic                     REF_CLK_I,
  input  wire logic                     RSTN_I,
  input  wire logic [7:0]               AVS_ADDRESS_I,
  input  wire logic                     AVS_READ_I,
  input  wire logic                     AVS_WRITE_I,
  input  wire logic [31:0]              AVS_WRITEDATA_I,
  input  wire logic [3:0]               AVS_BYTEENABLE_I,
  output logic [31:0]                   AVS_READDATA_O,
  output logic                          AVS_WAITREQUEST_O,
  input  wire logic [uab_pkg::FLEX_LINES-1:0] FLEX_IO_I,
  output logic [uab_pkg::FLEX_LINES-1:0]      FLEX_IO_O,
  output logic [uab_pkg::FLEX_LINES-1:0]      FLEX_IO_OE,
  input  wire logic                     SDA_I,
  output logic                          SDA_O,
  output logic                          SDA_OE,
  input  wire logic                     SCL_I,
  output logic                          SCL_O,
  output logic                          SCL_OE
);
  import uab_pkg::*;

  localparam logic [23:0] OLD_STEP = 24'(TIMER_BASE_HZ / ACC_UNIT_HZ);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [24:0] baud_adv(input logic [23:0] acc,
                                           input logic [23:0] step,
                                           input logic [23:0] thr);
    logic [23:0] sum;
    sum = acc + step;
    baud_adv = (sum >= thr) ? {1'b1, sum - thr} : {1'b0, sum};
  endfunction : baud_adv

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                 rxen_r;
  logic                 rev_r;
  logic [3:0]           pofs_r;
  logic [1:0]           tmr_r;
  logic [15:0]          baud_r;
  logic                 rd_done_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rd_word;
  logic                 rd_take;
  logic                 wr_take;
  logic [16:0]          sync1_r;
  logic [16:0]          sync2_r;
  logic [4:0]           tx_idx;
  logic [4:0]           rx_idx;
  logic                 rx_line;
  logic [16:0]          span;
  logic [23:0]          thr;
  logic [23:0]          step;
  uab_ser_t             tx_st_r;
  logic [23:0]          tx_acc_r;
  logic                 tx_half_r;
  logic [2:0]           tx_bit_r;
  logic [7:0]           tx_sh_r;
  logic                 tx_line_r;
  logic [24:0]          tx_adv;
  logic                 tx_bit_end;
  uab_ser_t             rx_st_r;
  logic [23:0]          rx_acc_r;
  logic                 rx_half_r;
  logic [2:0]           rx_bit_r;
  logic [7:0]           rx_sh_r;
  logic                 rx_done_r;
  logic [24:0]          rx_adv;
  logic                 rx_bit_end;
  logic                 ovf_r;
  logic                 ferr_r;
  logic                 flush;
  logic                 rx_push;
  logic                 rx_in_ready;
  logic                 rx_out_valid;
  logic [7:0]           rx_out_data;
  logic [5:0]           rx_cnt;
  logic                 tx_in_valid;
  logic                 tx_in_ready;
  logic                 tx_out_valid;
  logic [7:0]           tx_out_data;
  logic [6:0]           tx_cnt;
  logic                 tx_pop;
  logic [FLEX_LINES-1:0] flex_o_r;
  logic [FLEX_LINES-1:0] flex_oe_r;
  logic                 sda_o_r;
  logic                 sda_oe_r;

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  assign AVS_WAITREQUEST_O = (AVS_READ_I && !rd_done_r) ||
                             (AVS_WRITE_I && AVS_ADDRESS_I == OFS_TXDATA && !tx_in_ready);
  assign rd_take           = AVS_READ_I && !rd_done_r;
  assign wr_take           = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign AVS_READDATA_O    = rdata_r;
  assign flush             = wr_take && AVS_ADDRESS_I == OFS_FLUSH;
  assign tx_in_valid       = AVS_WRITE_I && AVS_ADDRESS_I == OFS_TXDATA;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (AVS_ADDRESS_I)
      OFS_CTRL: begin
        rd_word[CTRL_RXEN_BIT]           = rxen_r;
        rd_word[CTRL_REV_BIT]            = rev_r;
        rd_word[CTRL_OFS_LSB +: 4]       = pofs_r;
        rd_word[CTRL_TMR_LSB +: 2]       = tmr_r;
      end
      OFS_BAUD:   rd_word[15:0] = baud_r;
      OFS_RXDATA: rd_word[7:0]  = rx_out_valid ? rx_out_data : 8'h00;
      OFS_STATUS: begin
        rd_word[STAT_RXCNT_LSB +: 6]     = rx_cnt;
        rd_word[STAT_BUSY_BIT]           = (tx_st_r != S_IDLE) || tx_out_valid;
        rd_word[STAT_OVF_BIT]            = ovf_r;
        rd_word[STAT_FERR_BIT]           = ferr_r;
        rd_word[STAT_TXCNT_LSB +: 7]     = tx_cnt;
      end
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_done_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      rd_done_r <= rd_take;
      if (rd_take) rdata_r <= rd_word;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rxen_r <= CTRL_RXEN_RST;
      rev_r  <= CTRL_REV_RST;
      pofs_r <= CTRL_OFS_RST;
      tmr_r  <= CTRL_TMR_RST;
      baud_r <= BAUD_RST;
    end else if (wr_take) begin
      if (AVS_ADDRESS_I == OFS_CTRL && AVS_BYTEENABLE_I[0]) begin
        rxen_r <= AVS_WRITEDATA_I[CTRL_RXEN_BIT];
        rev_r  <= AVS_WRITEDATA_I[CTRL_REV_BIT];
        pofs_r <= AVS_WRITEDATA_I[CTRL_OFS_LSB +: 4];
      end
      if (AVS_ADDRESS_I == OFS_CTRL && AVS_BYTEENABLE_I[1]) tmr_r <= AVS_WRITEDATA_I[CTRL_TMR_LSB +: 2];
      if (AVS_ADDRESS_I == OFS_BAUD && AVS_BYTEENABLE_I[0]) baud_r[7:0] <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I == OFS_BAUD && AVS_BYTEENABLE_I[1]) baud_r[15:8] <= AVS_WRITEDATA_I[15:8];
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and mapping
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_r <= 17'h1FFFF;
      sync2_r <= 17'h1FFFF;
    end else begin
      sync1_r <= {SCL_I, FLEX_IO_I};
      sync2_r <= sync1_r;
    end
  end

  assign tx_idx  = 5'(pofs_r) + 5'(tmr_r);
  assign rx_idx  = tx_idx + 5'h01;
  assign rx_line = rev_r ? (rx_idx[4] ? 1'b1 : sync2_r[rx_idx[3:0]]) : sync2_r[16];

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      flex_o_r  <= {FLEX_LINES{1'b1}};
      flex_oe_r <= '0;
      sda_o_r   <= 1'b1;
      sda_oe_r  <= 1'b0;
    end else begin
      flex_o_r  <= {FLEX_LINES{1'b1}};
      flex_oe_r <= '0;
      if (rev_r && !tx_idx[4]) begin
        flex_o_r[tx_idx[3:0]]  <= tx_line_r;
        flex_oe_r[tx_idx[3:0]] <= 1'b1;
      end
      sda_o_r  <= rev_r ? 1'b1 : tx_line_r;
      sda_oe_r <= !rev_r;
    end
  end

  assign FLEX_IO_O  = flex_o_r;
  assign FLEX_IO_OE = flex_oe_r;
  assign SDA_O      = sda_o_r;
  assign SDA_OE     = sda_oe_r;
  assign SCL_O      = 1'b1;
  assign SCL_OE     = 1'b0;

  // ---------------------------------------------------------------
  // Baud generation
  // ---------------------------------------------------------------
  assign span = rev_r ? (NEW_SPAN - {1'b0, baud_r}) : {8'h00, OLD_SPAN - {1'b0, baud_r[7:0]}};
  assign thr  = rev_r ? 24'(span * ACC_PER_CLK) : 24'((span * ACC_PER_CLK) >> 1);
  assign step = rev_r ? NEW_STEP : OLD_STEP;
  assign tx_adv     = baud_adv(tx_acc_r, step, thr);
  assign rx_adv     = baud_adv(rx_acc_r, step, thr);
  assign tx_bit_end = tx_adv[24] && tx_half_r;
  assign rx_bit_end = rx_adv[24] && rx_half_r;

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  assign tx_pop = (tx_st_r == S_IDLE) && tx_out_valid;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_acc_r  <= '0;
      tx_half_r <= 1'b0;
    end else if (tx_st_r == S_IDLE) begin
      tx_acc_r  <= '0;
      tx_half_r <= 1'b0;
    end else begin
      tx_acc_r <= tx_adv[23:0];
      if (tx_adv[24]) tx_half_r <= !tx_half_r;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_st_r   <= S_IDLE;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h00;
      tx_line_r <= 1'b1;
    end else begin
      unique case (tx_st_r)
        S_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_pop) begin
            tx_sh_r   <= tx_out_data;
            tx_line_r <= 1'b0;
            tx_st_r   <= S_START;
          end
        end
        S_START: if (tx_bit_end) begin
          tx_st_r   <= S_DATA;
          tx_line_r <= tx_sh_r[0];
          tx_bit_r  <= 3'h0;
        end
        S_DATA: if (tx_bit_end) begin
          if (tx_bit_r == 3'(DATA_BITS - 1)) begin
            tx_st_r   <= S_STOP;
            tx_line_r <= 1'b1;
          end else begin
            tx_bit_r  <= tx_bit_r + 3'h1;
            tx_sh_r   <= {1'b0, tx_sh_r[7:1]};
            tx_line_r <= tx_sh_r[1];
          end
        end
        S_STOP: if (tx_bit_end) tx_st_r <= S_IDLE;
      endcase
    end
  end

  uab_fifo #(.WIDTH(DATA_BITS), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RSTN_I),
    .flush_i     (1'b0),
    .in_valid_i  (tx_in_valid),
    .in_ready_o  (tx_in_ready),
    .in_data_i   (AVS_WRITEDATA_I[7:0]),
    .out_valid_o (tx_out_valid),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_out_data),
    .count_o     (tx_cnt)
  );

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_acc_r  <= '0;
      rx_half_r <= 1'b0;
    end else if (rx_st_r == S_IDLE || rx_st_r == S_START) begin
      rx_acc_r  <= (rx_st_r == S_IDLE) ? 24'h000000 : rx_adv[23:0];
      rx_half_r <= 1'b0;
    end else begin
      rx_acc_r <= rx_adv[23:0];
      if (rx_adv[24]) rx_half_r <= !rx_half_r;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_st_r   <= S_IDLE;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      unique case (rx_st_r)
        S_IDLE: if (!rx_line) rx_st_r <= S_START;
        S_START: if (rx_adv[24]) begin
          rx_st_r  <= rx_line ? S_IDLE : S_DATA;
          rx_bit_r <= 3'h0;
        end
        S_DATA: if (rx_bit_end) begin
          rx_sh_r <= {rx_line, rx_sh_r[7:1]};
          if (rx_bit_r == 3'(DATA_BITS - 1)) rx_st_r <= S_STOP;
          rx_bit_r <= rx_bit_r + 3'h1;
        end
        S_STOP: if (rx_bit_end) begin
          rx_done_r <= rx_line;
          rx_st_r   <= S_IDLE;
        end
      endcase
    end
  end

  assign rx_push = rx_done_r && rxen_r;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ovf_r  <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      if (rx_push && !rx_in_ready) ovf_r <= 1'b1;
      else if (flush) ovf_r <= 1'b0;
      if (rx_st_r == S_STOP && rx_bit_end && !rx_line) ferr_r <= 1'b1;
      else if (flush) ferr_r <= 1'b0;
    end
  end

  uab_fifo #(.WIDTH(DATA_BITS), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RSTN_I),
    .flush_i     (flush),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_sh_r),
    .out_valid_o (rx_out_valid),
    .out_ready_i (rd_take && AVS_ADDRESS_I == OFS_RXDATA),
    .out_data_o  (rx_out_data),
    .count_o     (rx_cnt)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_tx_idle_high: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (tx_st_r == S_IDLE && $past(tx_st_r) == S_IDLE) |-> tx_line_r)
    else $error("Transmit line not idle high");
  a_tx_start_low: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (tx_st_r == S_START) |-> !tx_line_r)
    else $error("Start bit not low");
  a_tx_stop_bit: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (tx_st_r == S_DATA && tx_bit_end && tx_bit_r == 3'h7) |=> (tx_st_r == S_STOP && tx_line_r))
    else $error("Stop bit not after eighth data bit");
  a_rx_gate_en: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    !rxen_r |=> (rx_cnt <= $past(rx_cnt)))
    else $error("Byte buffered while receive disabled");
  a_rx_cap_32: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    rx_cnt <= 6'h20)
    else $error("Receive occupancy above 32");
  a_flush_empty: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    flush |=> (rx_cnt == 6'h00 && !rx_out_valid))
    else $error("Flush left bytes in buffer");
  a_sda_map: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    !rev_r |=> (SDA_OE && SDA_O == $past(tx_line_r) && FLEX_IO_OE == 16'h0000))
    else $error("Older revision transmit not on SDA");
  a_flex_map: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (rev_r && !tx_idx[4]) |=> (FLEX_IO_OE == (16'h0001 << $past(tx_idx)) && !SDA_OE))
    else $error("Newer revision transmit line misplaced");
endmodule : uab_top

//--- testbench/uab_peer.sv
/*
  Far-side serial device: 8N1 frame sender and frame checker.
  Assumes the bench hands it the resolved transmit wire and the clock.
*/
`timescale 1ns/1ps

module uab_peer #(
  parameter int BIT_CYC = 10
) (
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  logic [7:0] seen_q[$];
  logic [7:0] sh;
  int         bad_frames = 0;

  initial rx_line_o = 1'b1;  // Idle high, normal polarity

  // ---------------------------------------------------------------
  // Sender, called right after a rising edge
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] b, input logic stop = 1'b1);
    logic [9:0] f;
    f = {stop, b, 1'b0};  // Start low, LSB first, one stop, high by default
    for (int i = 0; i < 10; i++) begin
      rx_line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    rx_line_o <= 1'b1;
  endtask : send

  // ---------------------------------------------------------------
  // Frame checker, mid-bit sampling
  // ---------------------------------------------------------------
  always begin
    @(posedge clk_i iff tx_line_i === 1'b0);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    if (tx_line_i !== 1'b0) bad_frames++;  // Start bit low
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      sh[i] = tx_line_i;  // LSB first
    end
    repeat (BIT_CYC) @(posedge clk_i);
    if (tx_line_i !== 1'b1) bad_frames++;  // Single stop high
    seen_q.push_back(sh);
  end
endmodule : uab_peer

//--- testbench/uab_top_bench.sv
/*
  Self-checking bench of the buffered serial port with a queue model.
  Assumes the design files and the far-side model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module uab_top_bench;
  import uab_pkg::*;
  logic        clk, rst_n, rd, wr, sda_o, sda_oe, scl_o, scl_oe, wait_o, peer_rx, tx_w;
  logic [7:0]  adr, lfsr, x;
  logic [31:0] wdat, rdat, d;
  logic [15:0] fo, foe, fi;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  int          rev = 1, txi = 4, rxi = 5, en = 0, ovf = 0;
  int          mq[$], tq[$];

  initial clk = 1'b0;
  always #50 clk = ~clk;

  uab_top #(.TIMER_BASE_HZ(10_000_000)) DUT (
    .REF_CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o), .FLEX_IO_I(fi),
    .FLEX_IO_O(fo), .FLEX_IO_OE(foe), .SDA_I(1'b1), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .SCL_I(scl_oe ? scl_o : peer_rx), .SCL_O(scl_o), .SCL_OE(scl_oe));
  uab_peer #(.BIT_CYC(10)) peer (.clk_i(clk), .tx_line_i(tx_w), .rx_line_o(peer_rx));

  // Wire levels, pull-ups where nobody drives
  always_comb begin
    for (int i = 0; i < 16; i++) fi[i] = foe[i] ? fo[i] : (i == rxi ? peer_rx : 1'b1);
    tx_w = rev ? (foe[txi] ? fo[txi] : 1'b1) : (sda_oe ? sda_o : 1'b1);
  end

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  function automatic logic [31:0] ctrl(input int e, input int r, input int o, input int t);
    return 32'(e) << CTRL_RXEN_BIT | 32'(r) << CTRL_REV_BIT | 32'(o) << CTRL_OFS_LSB
      | 32'(t) << CTRL_TMR_LSB;
  endfunction : ctrl

  // ---------------------------------------------------------------
  // Bus master and serial helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    adr  <= a;
    wdat <= v;
    wr   <= w;
    rd   <= !w;
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rx_byte(input logic [7:0] b);
    if (en != 0 && mq.size() < 32) mq.push_back(b);
    else if (en != 0) ovf = 1;
    peer.send(b);
    repeat (3) @(posedge clk);
  endtask : rx_byte

  task automatic xfer(input logic [7:0] b);
    bus(1'b1, OFS_TXDATA, 32'(b));
    rx_byte(~b);
    repeat (20) @(posedge clk);
    `CHK(peer.seen_q.size(), 1)
    x = peer.seen_q.pop_front();
    `CHK(x, b)
    bus(1'b0, OFS_RXDATA, 0);
    x = 8'(mq.pop_front());
    `CHK(d[7:0], x)
  endtask : xfer

  task automatic report_and_stop;
    $display("Counts: %0d compared, %0d mismatched", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    lfsr = 8'h20;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_CTRL, 0);
    `CHK(d, ctrl(0, 1, 4, 0))
    bus(1'b0, OFS_BAUD, 0);
    `CHK(d, 32'h0000F63C)
    bus(1'b0, 8'h1C, 0);
    `CHK(d, 32'h0)
    `CHK(foe, 16'h0010)
    `CHK(tx_w, 1'b1)
    `CHK(fo, 16'hFFFF)
    `CHK({scl_oe, scl_o}, 2'b01)
    $display("TEST reset done");
    bus(1'b1, OFS_BAUD, 32'h0000FFE8);
    rx_byte(8'h5A);
    bus(1'b0, OFS_STATUS, 0);
    `CHK(d, 32'h0)
    bus(1'b1, OFS_CTRL, ctrl(1, 1, 4, 0));
    en = 1;
    for (int i = 0; i < 34; i++) begin
      lfsr = nxt(lfsr);
      rx_byte(lfsr);
    end
    bus(1'b0, OFS_STATUS, 0);
    `CHK(d, 32'(mq.size()) | 32'(ovf) << STAT_OVF_BIT)
    while (mq.size() > 0) begin
      bus(1'b0, OFS_STATUS, 0);
      `CHK(d[5:0], 6'(mq.size()))
      bus(1'b0, OFS_RXDATA, 0);
      x = 8'(mq.pop_front());
      `CHK(d[7:0], x)
    end
    bus(1'b0, OFS_RXDATA, 0);
    `CHK(d, 32'h0)
    $display("TEST receive done");
    for (int i = 0; i < 3; i++) rx_byte(8'(i + 1));
    peer.send(8'h00, 1'b0);
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_STATUS, 0);
    `CHK(d, 32'(mq.size()) | 32'(ovf) << STAT_OVF_BIT | 32'h1 << STAT_FERR_BIT)
    lfsr = nxt(lfsr);
    bus(1'b1, OFS_FLUSH, {4{lfsr}});
    mq.delete();
    ovf = 0;
    bus(1'b0, OFS_STATUS, 0);
    `CHK(d, 32'h0)
    $display("TEST flush done");
    for (int i = 0; i < 56; i++) begin
      lfsr = nxt(lfsr);
      tq.push_back(lfsr);
      bus(1'b1, OFS_TXDATA, {24'h0, lfsr});
    end
    rx_byte(8'hC3);
    bus(1'b0, OFS_STATUS, 0);
    `CHK(d[5:0], 6'(mq.size()))
    `CHK(d[8], 1'b1)
    while (d[8] !== 1'b0 || d[22:16] !== 7'h0) bus(1'b0, OFS_STATUS, 0);
    repeat (30) @(posedge clk);
    `CHK(peer.seen_q.size(), tq.size())
    `CHK(peer.bad_frames, 0)
    while (tq.size() > 0 && peer.seen_q.size() > 0) begin
      d = 32'(tq.pop_front());
      x = peer.seen_q.pop_front();
      `CHK(x, d[7:0])
    end
    tq.delete();
    bus(1'b0, OFS_RXDATA, 0);
    x = 8'(mq.pop_front());
    `CHK(d[7:0], x)
    $display("TEST transmit done");
    bus(1'b1, OFS_CTRL, ctrl(1, 1, 4, 1));
    txi = 5;
    rxi = 6;
    repeat (2) @(posedge clk);
    `CHK(foe, 16'h0020)
    xfer(8'h96);
    $display("TEST mapping done");
    bus(1'b1, OFS_BAUD, 32'h000000F6);
    bus(1'b1, OFS_CTRL, ctrl(1, 0, 4, 0));
    rev = 0;
    bus(1'b0, OFS_CTRL, 0);
    `CHK(d, ctrl(1, 0, 4, 0))
    `CHK({sda_oe, foe}, 17'h10000)
    xfer(nxt(lfsr));
    $display("TEST older revision done");
    report_and_stop();
  end
endmodule : uab_top_bench
